// ### logic/prld_pkg.sv
package prld_pkg;
  localparam int unsigned OPC_W = 10;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned RLD_W = 8;
  // Opcodes of the four load instructions
  localparam logic [9:0] OPC_LOAD_CONV_CTRL_FIRST = 10'h204;
  localparam logic [9:0] OPC_LOAD_CONV_CTRL_SECOND = 10'h205;
  localparam logic [9:0] OPC_LOAD_CONV_CTRL_THIRD = 10'h206;
  localparam logic [9:0] OPC_LOAD_TIMER_RELOAD_PAIR = 10'h23f;
  // Field positions inside the timer reload register
  localparam int unsigned RLD_HI_LSB = 4;
  localparam int unsigned RLD_LO_LSB = 0;
  // Values after reset
  localparam logic [3:0] RST_CONV_CTRL = 4'h0;
  localparam logic [7:0] RST_TIMER_RELOAD = 8'h00;
  // Cycles an instruction of this group takes
  localparam int unsigned LOAD_CYCLES = 1;
endpackage

// ### logic/prld_decode.sv
`timescale 1ns/1ps
module prld_decode (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [9:0] instr_opcode,
  input wire logic [3:0] acc,
  input wire logic [3:0] aux,
  output logic [3:0] conv_ctrl_first,
  output logic [3:0] conv_ctrl_second,
  output logic [3:0] conv_ctrl_third,
  output logic [7:0] timer_reload_first,
  output logic timer_reload_wr,
  output logic instr_claimed
);

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] conv_first_ff, conv_second_ff, conv_third_ff;
  logic [3:0] nxt_conv_first, nxt_conv_second, nxt_conv_third;
  logic [7:0] reload_ff, nxt_reload;
  logic reload_wr_ff, nxt_reload_wr;
  logic claimed_ff, nxt_claimed;
  logic hit_first, hit_second, hit_third, hit_pair;
  logic hit_any;

  function automatic logic opc_hit(input logic v, input logic [9:0] opc,
                                   input logic [9:0] code);
    opc_hit = v && (opc == code);
  endfunction

  assign hit_first = opc_hit(instr_valid, instr_opcode, prld_pkg::OPC_LOAD_CONV_CTRL_FIRST);
  assign hit_second = opc_hit(instr_valid, instr_opcode, prld_pkg::OPC_LOAD_CONV_CTRL_SECOND);
  assign hit_third = opc_hit(instr_valid, instr_opcode, prld_pkg::OPC_LOAD_CONV_CTRL_THIRD);
  assign hit_pair = opc_hit(instr_valid, instr_opcode, prld_pkg::OPC_LOAD_TIMER_RELOAD_PAIR);
  assign hit_any = hit_first | hit_second | hit_third | hit_pair;

  ////////////////////////////////////////////////////////////////////////////
  // The block only reads acc and aux; carry and skip stay with the core
  always_comb
  begin
    nxt_conv_first = conv_first_ff;
    nxt_conv_second = conv_second_ff;
    nxt_conv_third = conv_third_ff;
    nxt_reload = reload_ff;
    nxt_reload_wr = 1'b0;
    nxt_claimed = hit_any;
    if (hit_first)
    begin
      nxt_conv_first = acc;
    end
    if (hit_second)
    begin
      nxt_conv_second = acc;
    end
    if (hit_third)
    begin
      nxt_conv_third = acc;
    end
    if (hit_pair)
    begin
      nxt_reload[prld_pkg::RLD_HI_LSB +: prld_pkg::NIB_W] = aux;
      nxt_reload[prld_pkg::RLD_LO_LSB +: prld_pkg::NIB_W] = acc;
      nxt_reload_wr = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_first_ff <= prld_pkg::RST_CONV_CTRL;
      conv_second_ff <= prld_pkg::RST_CONV_CTRL;
      conv_third_ff <= prld_pkg::RST_CONV_CTRL;
      reload_ff <= prld_pkg::RST_TIMER_RELOAD;
      reload_wr_ff <= 1'b0;
      claimed_ff <= 1'b0;
    end
    else
    begin
      conv_first_ff <= nxt_conv_first;
      conv_second_ff <= nxt_conv_second;
      conv_third_ff <= nxt_conv_third;
      reload_ff <= nxt_reload;
      reload_wr_ff <= nxt_reload_wr;
      claimed_ff <= nxt_claimed;
    end
  end

  assign conv_ctrl_first = conv_first_ff;
  assign conv_ctrl_second = conv_second_ff;
  assign conv_ctrl_third = conv_third_ff;
  assign timer_reload_first = reload_ff;
  assign timer_reload_wr = reload_wr_ff;
  assign instr_claimed = claimed_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_first_load;
    @(posedge core_clk) disable iff (!arst_n)
      hit_first |=> conv_ctrl_first == $past(acc);
  endproperty
  a_first_load: assert property (p_first_load)
    else $error("first converter control not loaded from acc");

  property p_second_load;
    @(posedge core_clk) disable iff (!arst_n)
      hit_second |=> conv_ctrl_second == $past(acc);
  endproperty
  a_second_load: assert property (p_second_load)
    else $error("second converter control not loaded from acc");

  property p_third_load;
    @(posedge core_clk) disable iff (!arst_n)
      hit_third |=> conv_ctrl_third == $past(acc);
  endproperty
  a_third_load: assert property (p_third_load)
    else $error("third converter control not loaded from acc");

  property p_reload_hi;
    @(posedge core_clk) disable iff (!arst_n)
      hit_pair |=> timer_reload_first[7:4] == $past(aux) && timer_reload_wr;
  endproperty
  a_reload_hi: assert property (p_reload_hi)
    else $error("reload upper nibble not taken from aux");

  property p_reload_lo;
    @(posedge core_clk) disable iff (!arst_n)
      hit_pair |=> timer_reload_first[3:0] == $past(acc);
  endproperty
  a_reload_lo: assert property (p_reload_lo)
    else $error("reload lower nibble not taken from acc");

  property p_claim;
    @(posedge core_clk) disable iff (!arst_n)
      instr_valid && !(hit_first || hit_second || hit_third || hit_pair)
        |=> !instr_claimed && $stable(conv_ctrl_first) && $stable(timer_reload_first);
  endproperty
  a_claim: assert property (p_claim)
    else $error("foreign opcode changed block state");

  // A register moves only on its own opcode
  property p_hold_first;
    @(posedge core_clk) disable iff (!arst_n)
      !hit_first |=> $stable(conv_ctrl_first);
  endproperty
  a_hold_first: assert property (p_hold_first)
    else $error("first converter control changed without its opcode");

  property p_hold_second;
    @(posedge core_clk) disable iff (!arst_n)
      !hit_second |=> $stable(conv_ctrl_second);
  endproperty
  a_hold_second: assert property (p_hold_second)
    else $error("second converter control changed without its opcode");

  property p_hold_third;
    @(posedge core_clk) disable iff (!arst_n)
      !hit_third |=> $stable(conv_ctrl_third);
  endproperty
  a_hold_third: assert property (p_hold_third)
    else $error("third converter control changed without its opcode");

  property p_hold_reload;
    @(posedge core_clk) disable iff (!arst_n)
      !hit_pair |=> $stable(timer_reload_first);
  endproperty
  a_hold_reload: assert property (p_hold_reload)
    else $error("timer reload changed without the pair opcode");

  property p_wr_pulse;
    @(posedge core_clk) disable iff (!arst_n)
      timer_reload_wr |-> $past(hit_pair);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("reload strobe without pair opcode");

  property p_claim_follow;
    @(posedge core_clk) disable iff (!arst_n)
      hit_any |=> instr_claimed;
  endproperty
  a_claim_follow: assert property (p_claim_follow)
    else $error("claim pulse missing after a load opcode");

  property p_claim_pulse;
    @(posedge core_clk) disable iff (!arst_n)
      instr_claimed |-> $past(hit_any);
  endproperty
  a_claim_pulse: assert property (p_claim_pulse)
    else $error("claim pulse without a load opcode");

  property p_conv_no_wr;
    @(posedge core_clk) disable iff (!arst_n)
      (hit_first || hit_second || hit_third) |=> !timer_reload_wr;
  endproperty
  a_conv_no_wr: assert property (p_conv_no_wr)
    else $error("reload strobe after a converter load");

  property p_claim_quiet;
    @(posedge core_clk) disable iff (!arst_n)
      !instr_valid |=> !instr_claimed && !timer_reload_wr;
  endproperty
  a_claim_quiet: assert property (p_claim_quiet)
    else $error("pulse raised without a valid instruction");

  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios: each load kind and back to back loads
  c_first: cover property (@(posedge core_clk) disable iff (!arst_n) hit_first);
  c_pair: cover property (@(posedge core_clk) disable iff (!arst_n) hit_pair);
  c_back: cover property (@(posedge core_clk) disable iff (!arst_n) hit_second ##1 hit_pair);
  c_second: cover property (@(posedge core_clk) disable iff (!arst_n) hit_second);
  c_third: cover property (@(posedge core_clk) disable iff (!arst_n) hit_third);
endmodule

// ### test/test_prld_decode.sv
`timescale 1ns/1ps
module test_prld_decode;
  logic core_clk;
  logic arst_n;
  logic instr_valid;
  logic [9:0] instr_opcode;
  logic [3:0] acc;
  logic [3:0] aux;
  logic [3:0] c1;
  logic [3:0] c2;
  logic [3:0] c3;
  logic [7:0] rld;
  logic rld_wr;
  logic claimed;
  logic [3:0] exp_c [3];
  int errors;
  int total_checks;

  prld_decode i_dut (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .acc(acc), .aux(aux), .conv_ctrl_first(c1),
    .conv_ctrl_second(c2), .conv_ctrl_third(c3), .timer_reload_first(rld),
    .timer_reload_wr(rld_wr), .instr_claimed(claimed));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One instruction; returns in the cycle where its pulses stand
  task issue(input logic [9:0] opc, input logic [3:0] a, input logic [3:0] b, input logic v);
    @(negedge core_clk);
    instr_valid = v;
    instr_opcode = opc;
    acc = a;
    aux = b;
    @(negedge core_clk);
    instr_valid = 1'b0;
    acc = ~a;
    aux = ~b;
  endtask

  task check_regs(input logic [7:0] exp_rld, input logic exp_wr, input logic exp_cl);
    check("conv_ctrl_first", {4'h0, c1}, {4'h0, exp_c[0]});
    check("conv_ctrl_second", {4'h0, c2}, {4'h0, exp_c[1]});
    check("conv_ctrl_third", {4'h0, c3}, {4'h0, exp_c[2]});
    check("timer_reload_first", rld, exp_rld);
    check("timer_reload_wr", {7'h0, rld_wr}, {7'h0, exp_wr});
    check("instr_claimed", {7'h0, claimed}, {7'h0, exp_cl});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task test_conv;
    for (int i = 0; i < 3; i++)
    begin
      issue(prld_pkg::OPC_LOAD_CONV_CTRL_FIRST + 10'(i), 4'(4 * i + 9), 4'h6, 1'b1);
      exp_c[i] = 4'(4 * i + 9);
      check_regs(8'h00, 1'b0, 1'b1);
    end
    $display("test_conv done");
  endtask

  task test_pair;
    issue(prld_pkg::OPC_LOAD_TIMER_RELOAD_PAIR, 4'h0, 4'hf, 1'b1);
    check_regs(8'hf0, 1'b1, 1'b1);
    @(negedge core_clk);
    instr_valid = 1'b1;
    acc = 4'h3;
    aux = 4'hc;
    @(negedge core_clk);
    check("timer_reload_first", rld, 8'hc3);
    check("timer_reload_wr", {7'h0, rld_wr}, 8'h01);
    acc = 4'ha;
    aux = 4'h5;
    issue(prld_pkg::OPC_LOAD_CONV_CTRL_THIRD, 4'h7, 4'h2, 1'b1);
    exp_c[2] = 4'h7;
    check_regs(8'h5a, 1'b0, 1'b1);
    $display("test_pair done");
  endtask

  task test_ignore;
    issue(prld_pkg::OPC_LOAD_CONV_CTRL_FIRST, 4'h1, 4'h1, 1'b0);
    check_regs(8'h5a, 1'b0, 1'b0);
    issue(10'h207, 4'h2, 4'h2, 1'b1);
    check_regs(8'h5a, 1'b0, 1'b0);
    issue(10'h23e, 4'h3, 4'h3, 1'b1);
    check_regs(8'h5a, 1'b0, 1'b0);
    issue(10'h004, 4'h4, 4'h4, 1'b1);
    check_regs(8'h5a, 1'b0, 1'b0);
    arst_n = 1'b0;
    exp_c = '{4'h0, 4'h0, 4'h0};
    @(negedge core_clk);
    check_regs(8'h00, 1'b0, 1'b0);
    arst_n = 1'b1;
    issue(prld_pkg::OPC_LOAD_CONV_CTRL_SECOND, 4'h8, 4'h3, 1'b1);
    exp_c[1] = 4'h8;
    check_regs(8'h00, 1'b0, 1'b1);
    $display("test_ignore done");
  endtask

  task end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #100us;
    errors++;
    end_of_test();
  end

  initial
  begin
    errors = 0;
    total_checks = 0;
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_opcode = 10'h000;
    acc = 4'h0;
    aux = 4'h0;
    exp_c = '{4'h0, 4'h0, 4'h0};
    repeat (6) @(negedge core_clk);
    check_regs(8'h00, 1'b0, 1'b0);
    arst_n = 1'b1;
    test_conv();
    test_pair();
    test_ignore();
    end_of_test();
  end
endmodule
